/* srafe_host_model.sv */
module srafe_host_model (
  input wire logic clk,
  input wire logic dout,
  input wire logic dout_oe,
  output logic sclk,
  output logic din
);
  timeunit 1ns;
  timeprecision 1ns;

  // clk cycles per serial phase; the bench varies it for slow hosts
  int half = 6;

  initial begin
    sclk = 1'b1; // idle high outside frames
    din = 1'b0;
  end

  // ---------------------------------------------------------------
  // one frame of n bits
  // ---------------------------------------------------------------
  task automatic xfer(input int n, input logic [23:0] w,
      output logic [23:0] r, output logic oe_ok);
    r = 24'h000000;
    oe_ok = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      #1;
      // a read bit stands until the fall that launches the next one
      r[i] = dout;
      oe_ok = oe_ok & dout_oe;
      sclk = 1'b0;
      din = w[i];
      repeat (half) @(posedge clk);
      #1;
      sclk = 1'b1;
      repeat (half - 1) @(posedge clk);
    end
    // released line must not keep its last value
    #1;
    din = ~din;
  endtask : xfer
endmodule : srafe_host_model

/* srafe_pkg.sv */
package srafe_pkg;

  // ---------------------------------------------------------------
  // serial framing
  // ---------------------------------------------------------------
  localparam int CMD_BITS = 8;
  localparam int SHORT_BITS = 8;
  localparam int LONG_BITS = 24;
  localparam int RESYNC_ONES = 32;
  localparam logic [4:0] LAST_CMD = 5'(CMD_BITS - 1);
  localparam logic [4:0] LAST_SHORT = 5'(SHORT_BITS - 1);
  localparam logic [4:0] LAST_LONG = 5'(LONG_BITS - 1);

  // ---------------------------------------------------------------
  // register select codes and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] SEL_COMM = 3'h0;
  localparam logic [2:0] SEL_MODE = 3'h1;
  localparam logic [2:0] SEL_FHI = 3'h2;
  localparam logic [2:0] SEL_FLO = 3'h3;
  localparam logic [2:0] SEL_TEST = 3'h4;
  localparam logic [2:0] SEL_DATA = 3'h5;
  localparam logic [2:0] SEL_ZERO = 3'h6;
  localparam logic [2:0] SEL_FULL = 3'h7;
  localparam logic [2:0] CH_RST = 3'h4;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] FHI_RST = 8'h00;
  localparam logic [7:0] FLO_RST = 8'h00;
  localparam logic [7:0] TEST_RST = 8'h00;
  localparam logic [23:0] COEF_RST = 24'h000000;
  localparam int CAL_PAIRS = 3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SRAFE_IDLE = 2'b00,
    SRAFE_WR = 2'b01,
    SRAFE_RD = 2'b10
  } srafe_state_e;

  typedef struct packed {
    logic write_gate_bit;
    logic [2:0] register_select;
    logic rd;
    logic [2:0] input_pair_select;
  } srafe_cmd_s;

  // channel code to calibration pair
  function automatic logic [1:0] srafe_pair(input logic [2:0] ch);
    case (ch)
      3'h0, 3'h4: srafe_pair = 2'h0;
      3'h1, 3'h5: srafe_pair = 2'h1;
      default: srafe_pair = 2'h2;
    endcase
  endfunction : srafe_pair

endpackage : srafe_pkg

/* srafe_sclk_front.sv */
module srafe_sclk_front
  import srafe_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic din,
  output logic rise_q,
  output logic fall_q,
  output logic din_q,
  output logic resync_q
);

  // ---------------------------------------------------------------
  // edge detect and ones counter
  // ---------------------------------------------------------------
  logic sclk_q;
  logic [5:0] ones_q;
  logic rise_d;
  logic fall_d;
  logic resync_d;
  logic [5:0] ones_d;

  always_comb begin
    rise_d = sclk && !sclk_q;
    fall_d = !sclk && sclk_q;
    resync_d = 1'b0;
    ones_d = ones_q;
    if (rise_d) begin
      if (!din) begin
        ones_d = 6'h00;
      end else if (ones_q == 6'(RESYNC_ONES - 1)) begin
        // a full run of ones restarts the count for the next run
        resync_d = 1'b1;
        ones_d = 6'h00;
      end else begin
        ones_d = ones_q + 6'h01;
      end
    end
  end

  // idle-high clock assumed: reset value avoids a false edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_q <= 1'b1;
      ones_q <= 6'h00;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      din_q <= 1'b0;
      resync_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      ones_q <= ones_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      din_q <= din;
      resync_q <= resync_d;
    end
  end

endmodule : srafe_sclk_front

/* srafe_top.sv */
module srafe_top
  import srafe_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic din,
  input wire logic [23:0] conv_data,
  input wire logic conversion_ready_n,
  output logic dout_q,
  output logic dout_oe_q,
  output logic [2:0] input_pair_select_q,
  output logic [7:0] mode_q,
  output logic [7:0] filter_high_q,
  output logic [7:0] filter_low_q,
  output logic [7:0] test_q,
  output logic [23:0] zero_coef_q,
  output logic [23:0] full_coef_q
);

  // ---------------------------------------------------------------
  // serial clock front end
  // ---------------------------------------------------------------
  logic rise;
  logic fall;
  logic din_s;
  logic resync;

  srafe_sclk_front u_front (
    .clk(clk),
    .nrst(nrst),
    .sclk(sclk),
    .din(din),
    .rise_q(rise),
    .fall_q(fall),
    .din_q(din_s),
    .resync_q(resync)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  srafe_state_e st_q, st_d;
  srafe_cmd_s cmd_q, cmd_d;
  logic [4:0] cnt_q, cnt_d;
  logic [4:0] last_q, last_d;
  logic [23:0] sh_q, sh_d;
  logic [23:0] out_q, out_d;
  logic dout_d;
  logic oe_d;
  logic [7:0] mode_d, fhi_d, flo_d, test_d;
  logic [23:0] zero_q [CAL_PAIRS];
  logic [23:0] full_q [CAL_PAIRS];
  logic [23:0] zero_d [CAL_PAIRS];
  logic [23:0] full_d [CAL_PAIRS];
  logic [23:0] zc_d, fc_d;
  logic [23:0] word;
  srafe_cmd_s ncmd;
  logic [23:0] rdval;
  logic [1:0] npair;

  always_comb begin
    st_d = st_q;
    cmd_d = cmd_q;
    cnt_d = cnt_q;
    last_d = last_q;
    sh_d = sh_q;
    out_d = out_q;
    dout_d = dout_q;
    oe_d = dout_oe_q;
    mode_d = mode_q;
    fhi_d = filter_high_q;
    flo_d = filter_low_q;
    test_d = test_q;
    zero_d = zero_q;
    full_d = full_q;
    word = {sh_q[22:0], din_s};
    ncmd = srafe_cmd_s'(word[7:0]);
    npair = srafe_pair(ncmd.input_pair_select);
    // left aligned so every width leaves msb first
    case (ncmd.register_select)
      SEL_COMM: rdval = {conversion_ready_n, word[6:0], 16'h0000};
      SEL_MODE: rdval = {mode_q, 16'h0000};
      SEL_FHI: rdval = {filter_high_q, 16'h0000};
      SEL_FLO: rdval = {filter_low_q, 16'h0000};
      SEL_TEST: rdval = {test_q, 16'h0000};
      SEL_DATA: rdval = conv_data;
      SEL_ZERO: rdval = zero_q[npair];
      default: rdval = full_q[npair];
    endcase
    if (resync) begin
      st_d = SRAFE_IDLE;
      cnt_d = 5'h00;
      oe_d = 1'b0;
    end else if (rise) begin
      case (st_q)
        SRAFE_IDLE: begin
          // a leading one holds at bit zero
          if (!(cnt_q == 5'h00 && din_s)) begin
            sh_d = word;
            if (cnt_q == LAST_CMD) begin
              cmd_d = ncmd;
              cnt_d = 5'h00;
              last_d = (ncmd.register_select >= SEL_DATA) ?
                       LAST_LONG : LAST_SHORT;
              if (ncmd.rd) begin
                st_d = SRAFE_RD;
                dout_d = rdval[23];
                out_d = {rdval[22:0], 1'b0};
                oe_d = 1'b1;
              end else begin
                st_d = SRAFE_WR;
              end
            end else begin
              cnt_d = cnt_q + 5'h01;
            end
          end
        end
        SRAFE_WR: begin
          sh_d = word;
          if (cnt_q == last_q) begin
            st_d = SRAFE_IDLE;
            cnt_d = 5'h00;
            case (cmd_q.register_select)
              SEL_COMM: cmd_d.input_pair_select = word[2:0];
              SEL_MODE: mode_d = word[7:0];
              SEL_FHI: fhi_d = word[7:0];
              SEL_FLO: flo_d = word[7:0];
              SEL_TEST: test_d = word[7:0];
              SEL_ZERO:
                zero_d[srafe_pair(cmd_q.input_pair_select)] = word;
              SEL_FULL:
                full_d[srafe_pair(cmd_q.input_pair_select)] = word;
              default: ; // result register is read only
            endcase
          end else begin
            cnt_d = cnt_q + 5'h01;
          end
        end
        SRAFE_RD: begin
          if (cnt_q == last_q) begin
            st_d = SRAFE_IDLE;
            cnt_d = 5'h00;
            oe_d = 1'b0;
          end else begin
            cnt_d = cnt_q + 5'h01;
          end
        end
        default: begin
          st_d = SRAFE_IDLE;
          cnt_d = 5'h00;
        end
      endcase
    end else if (fall && st_q == SRAFE_RD) begin
      dout_d = out_q[23];
      out_d = {out_q[22:0], 1'b0};
    end
    zc_d = zero_d[srafe_pair(cmd_d.input_pair_select)];
    fc_d = full_d[srafe_pair(cmd_d.input_pair_select)];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= SRAFE_IDLE;
      cmd_q <= srafe_cmd_s'({1'b0, SEL_COMM, 1'b0, CH_RST});
      cnt_q <= 5'h00;
      last_q <= LAST_SHORT;
      sh_q <= 24'h000000;
      out_q <= 24'h000000;
      dout_q <= 1'b0;
      dout_oe_q <= 1'b0;
      input_pair_select_q <= CH_RST;
      mode_q <= MODE_RST;
      filter_high_q <= FHI_RST;
      filter_low_q <= FLO_RST;
      test_q <= TEST_RST;
      zero_coef_q <= COEF_RST;
      full_coef_q <= COEF_RST;
      for (int i = 0; i < CAL_PAIRS; i++) begin
        zero_q[i] <= COEF_RST;
        full_q[i] <= COEF_RST;
      end
    end else begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      cnt_q <= cnt_d;
      last_q <= last_d;
      sh_q <= sh_d;
      out_q <= out_d;
      dout_q <= dout_d;
      dout_oe_q <= oe_d;
      input_pair_select_q <= cmd_d.input_pair_select;
      mode_q <= mode_d;
      filter_high_q <= fhi_d;
      filter_low_q <= flo_d;
      test_q <= test_d;
      zero_coef_q <= zc_d;
      full_coef_q <= fc_d;
      zero_q <= zero_d;
      full_q <= full_d;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  resync_idle_a: assert property (
    resync |=> st_q == SRAFE_IDLE && cnt_q == 5'h00)
    else $error("resync did not return to idle");
  gate_hold_a: assert property (
    !resync && rise && st_q == SRAFE_IDLE && cnt_q == 5'h00 && din_s
    |=> st_q == SRAFE_IDLE && cnt_q == 5'h00)
    else $error("leading one advanced the command");
  cmd_dir_a: assert property (
    !resync && rise && st_q == SRAFE_IDLE && cnt_q == LAST_CMD
    |=> st_q == ($past(sh_q[2]) ? SRAFE_RD : SRAFE_WR))
    else $error("command direction wrong");
  width_sel_a: assert property (
    $changed(st_q) && st_q != SRAFE_IDLE
    |-> last_q == ((cmd_q.register_select >= SEL_DATA) ?
                   LAST_LONG : LAST_SHORT))
    else $error("access length wrong");
  done_idle_a: assert property (
    !resync && rise && st_q != SRAFE_IDLE && cnt_q == last_q
    |=> st_q == SRAFE_IDLE && !dout_oe_q)
    else $error("no return after access");
  msb_first_a: assert property (
    !resync && !rise && fall && st_q == SRAFE_RD
    |=> dout_q == $past(out_q[23]))
    else $error("read bit order wrong");
  reset_idle_a: assert property (
    $rose(nrst) |-> st_q == SRAFE_IDLE && cnt_q == 5'h00 && !dout_oe_q)
    else $error("port not idle after reset");
  comm_read_a: assert property (
    !resync && rise && st_q == SRAFE_IDLE && cnt_q == LAST_CMD && sh_q[2]
    && sh_q[5:3] == SEL_COMM
    |=> dout_oe_q && dout_q == $past(conversion_ready_n))
    else $error("ready flag not shown");
  data_read_a: assert property (
    !resync && rise && st_q == SRAFE_IDLE && cnt_q == LAST_CMD && sh_q[2]
    && sh_q[5:3] == SEL_DATA
    |=> dout_q == $past(conv_data[23]))
    else $error("result msb not shown");
  mode_wr_a: assert property (
    !resync && rise && st_q == SRAFE_WR && cnt_q == last_q
    && cmd_q.register_select == SEL_MODE
    |=> mode_q == $past(word[7:0]))
    else $error("mode write lost");

  read_seen_c: cover property (st_q == SRAFE_RD ##1 st_q == SRAFE_IDLE);
  cal_write_c: cover property (st_q == SRAFE_WR
    && cmd_q.register_select == SEL_FULL ##1 st_q == SRAFE_IDLE);
  resync_seen_c: cover property (resync);

endmodule : srafe_top

/* tb.sv */
module tb
  import srafe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic nrst, sclk, din, conversion_ready_n, dout_q, dout_oe_q, oe;
  logic [23:0] conv_data, zero_coef_q, full_coef_q, rd, v;
  logic [2:0] input_pair_select_q, ch;
  logic [7:0] mode_q, filter_high_q, filter_low_q, test_q;
  logic [7:0] m [1:4];
  logic [23:0] zc [3];
  logic [23:0] fc [3];
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  int seed;

  always #50 clk = ~clk;

  srafe_top DUT (.clk(clk), .nrst(nrst), .sclk(sclk), .din(din),
    .conv_data(conv_data), .conversion_ready_n(conversion_ready_n),
    .dout_q(dout_q), .dout_oe_q(dout_oe_q),
    .input_pair_select_q(input_pair_select_q), .mode_q(mode_q),
    .filter_high_q(filter_high_q), .filter_low_q(filter_low_q),
    .test_q(test_q), .zero_coef_q(zero_coef_q),
    .full_coef_q(full_coef_q));

  srafe_host_model host (.clk(clk), .dout(dout_q), .dout_oe(dout_oe_q),
    .sclk(sclk), .din(din));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [1:0] pair_of(input logic [2:0] c);
    if (c == 3'h0 || c == 3'h4) return 2'h0;
    if (c == 3'h1 || c == 3'h5) return 2'h1;
    return 2'h2;
  endfunction : pair_of

  function automatic logic [23:0] cmd(input logic [2:0] s,
      input logic r, input logic [2:0] c);
    return {16'h0000, 1'b0, s, r, c};
  endfunction : cmd

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] s, input logic [23:0] val);
    host.half = 6 + $urandom_range(2);
    host.xfer(8, cmd(s, 1'b0, ch), rd, oe);
    host.xfer((s >= SEL_DATA) ? 24 : 8, val, rd, oe);
  endtask : wr

  task automatic rdreg(input logic [2:0] s, input int n);
    host.half = 6 + $urandom_range(2);
    host.xfer(8, cmd(s, 1'b1, ch), rd, oe);
    host.xfer(n, 24'hffffff, rd, oe);
    chk(64'(oe), 64'h1);
  endtask : rdreg

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // a hang costs far more than the ~20k cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    conv_data = 24'h000000;
    conversion_ready_n = 1'b1;
    ch = CH_RST;
    m = '{default: 8'h00};
    seed = $urandom(32'h9619);
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    chk({28'h0, dout_oe_q, input_pair_select_q, mode_q, filter_high_q,
      filter_low_q, test_q}, {29'h0, CH_RST, 32'h0});
    chk({16'h0, zero_coef_q, full_coef_q}, 64'h0);
    $display("test reset done");
    for (int k = 0; k < 12; k++) begin
      v = 24'($urandom);
      wr(3'(1 + k % 4), {16'h0, v[7:0]});
      m[1 + k % 4] = v[7:0];
      rdreg(3'(1 + k % 4), 8);
      chk(64'(rd), 64'(m[1 + k % 4]));
      chk({mode_q, filter_high_q, filter_low_q, test_q},
        {m[1], m[2], m[3], m[4]});
    end
    wr(SEL_COMM, 24'h000005);
    chk(64'(input_pair_select_q), 64'h5);
    $display("test short registers done");
    for (int k = 0; k < 6; k++) begin
      ch = 3'($urandom);
      conversion_ready_n = 1'($urandom);
      rdreg(SEL_COMM, 8);
      chk(64'(rd), 64'({conversion_ready_n, SEL_COMM, 1'b1, ch}));
      chk(64'(input_pair_select_q), 64'(ch));
      conv_data = 24'($urandom);
      rdreg(SEL_DATA, 24);
      chk(64'(rd), 64'(conv_data));
    end
    wr(SEL_DATA, 24'h5a5a5a);
    rdreg(SEL_MODE, 8);
    chk(64'(rd), 64'(m[1]));
    $display("test status and data done");
    for (int p = 0; p < 3; p++) begin
      ch = 3'(p);
      zc[p] = 24'($urandom);
      fc[p] = 24'($urandom);
      wr(SEL_ZERO, zc[p]);
      wr(SEL_FULL, fc[p]);
    end
    for (int c = 0; c < 8; c++) begin
      ch = 3'(c);
      rdreg(SEL_ZERO, 24);
      chk(64'(rd), 64'(zc[pair_of(ch)]));
      rdreg(SEL_FULL, 24);
      chk(64'(rd), 64'(fc[pair_of(ch)]));
      chk({16'h0, zero_coef_q, full_coef_q},
        {16'h0, zc[pair_of(ch)], fc[pair_of(ch)]});
    end
    $display("test calibration done");
    v = 24'($urandom) & 24'h00007f;
    host.xfer(3, 24'h000007, rd, oe);
    wr(SEL_MODE, v);
    m[1] = v[7:0];
    chk(64'(mode_q), 64'(m[1]));
    // partial command, then a run of ones long enough to resync
    host.xfer(5, cmd(SEL_MODE, 1'b0, 3'h0) >> 3, rd, oe);
    host.xfer(24, 24'hffffff, rd, oe);
    host.xfer(8, 24'h0000ff, rd, oe);
    // the first ones finish the cut mode write on channel 7
    ch = 3'h7;
    m[1] = 8'hff;
    chk({61'h0, input_pair_select_q}, {61'h0, ch});
    rdreg(SEL_MODE, 8);
    chk(64'(rd), 64'(m[1]));
    $display("test framing recovery done");
    wrap_up();
  end
endmodule : tb
